// ===== rtl/lfwk_pkg.sv
// lfwk_pkg: constants, register map and state type of the wake-up correlator
package lfwk_pkg;
   // ************************************************
   // timing
   // ************************************************
   localparam int unsigned PCLK_HZ = 20000000;
   localparam int unsigned LF_HZ = 32768;
   localparam int unsigned TO_STEP_MS = 50;
   localparam int unsigned TO_STEP_CYC = TO_STEP_MS * (PCLK_HZ / 1000);
   localparam int unsigned ART_SEC_S = 1;
   localparam int unsigned ART_SEC_CYC = ART_SEC_S * PCLK_HZ;
   localparam int unsigned SCAN_MS = 1;
   localparam int unsigned SCAN_CYC = SCAN_MS * (PCLK_HZ / 1000);
   localparam logic [5:0] PRE_MIN_CHIPS = 6'h06;
   localparam logic [6:0] PRE_MAX_CHIPS = 7'h40;
   localparam logic [6:0] PAT_SLACK = 7'h10;
   localparam logic [6:0] PLEN16 = 7'h10;
   localparam logic [6:0] PLEN32 = 7'h20;
   // ************************************************
   // register map
   // ************************************************
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_PATTERN = 8'h04;
   localparam logic [7:0] ADDR_SYMDIV = 8'h08;
   localparam logic [7:0] ADDR_ARTPER = 8'h0c;
   localparam logic [7:0] ADDR_CMD = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;
   localparam logic [7:0] ADDR_CALRES = 8'h18;
   // control fields
   localparam int C_CHEN = 0;
   localparam int C_LP = 3;
   localparam int C_RC = 5;
   localparam int C_CALSRC = 6;
   localparam int C_BURST = 7;
   localparam int C_UPDN = 8;
   localparam int C_MASK = 9;
   localparam int C_DISP = 10;
   localparam int C_CORR = 11;
   localparam int C_MANCH = 12;
   localparam int C_P32 = 13;
   localparam int C_DBL = 14;
   localparam int C_TOL = 15;
   localparam int C_TO = 16;
   localparam int C_ART = 19;
   // command bits
   localparam int K_CLRWAKE = 0;
   localparam int K_RSSI = 1;
   localparam int K_FALSE = 2;
   localparam int K_CAL = 3;
   // status fields
   localparam int S_WAKE = 0;
   localparam int S_SEQ = 1;
   localparam int S_FALSE = 8;
   localparam int S_RSSI = 16;
   localparam int S_GAIN = 21;
   localparam int S_CHAN = 25;
   localparam int S_CAL = 28;
   // reset values and limits
   localparam logic [19:0] CTRL_RST = 20'h00807;
   localparam logic [15:0] PAT_RST = 16'h9669;
   localparam logic [6:0] SYMDIV_RST = 7'h18;
   localparam logic [6:0] SYMDIV_MIN = 7'h08;
   localparam logic [6:0] SYMDIV_MAX = 7'h40;
   localparam logic [12:0] ARTPER_RST = 13'h0001;
   localparam logic [12:0] ARTPER_MAX = 13'h1c20;
   localparam logic [3:0] GAIN_MAX = 4'hf;
   localparam logic [2:0] CHAN_RST = 3'h7;
   // ************************************************
   // types
   // ************************************************
   typedef enum logic [2:0] {ST_IDLE, ST_BURST, ST_PREAMB, ST_PATT, ST_PATT2, ST_DATA} lfwk_seq_t;
   typedef struct packed {
      logic [19:0] ctrl;
      logic [15:0] pattern;
      logic [6:0] symdiv;
      logic [12:0] artper;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      lfwk_seq_t st;
      logic [24:0] acc;
      logic gen_clk;
      logic rx_prev;
      logic [5:0] chip_ph;
      logic [31:0] shreg;
      logic [6:0] chip_n;
      logic [5:0] pre_cnt;
      logic wake;
      logic [31:0] to_cnt;
      logic [31:0] sec_cnt;
      logic [12:0] art_sec;
      logic [31:0] scan_cnt;
      logic [2:0] chan_active;
      logic [3:0] gain;
      logic [4:0] rssi_held;
      logic [7:0] false_cnt;
      logic chip_odd;
      logic dec_bit;
      logic rec_clk;
      logic rx_bit_out;
      logic rx_clock_out;
      logic cal_busy;
      logic cal_arm;
      logic cal_prev;
      logic [15:0] cal_cnt;
      logic [15:0] cal_res;
   } lfwk_state_t;
   localparam lfwk_state_t STATE_RST = '{ctrl: CTRL_RST, pattern: PAT_RST, symdiv: SYMDIV_RST,
      artper: ARTPER_RST, st: ST_IDLE, gain: GAIN_MAX, chan_active: CHAN_RST, default: '0};
endpackage : lfwk_pkg

// ===== rtl/lfwk_top.sv
// lfwk_top: apb-controlled wake-up correlator of a three-channel lf receiver
//
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
module lfwk_top #(
   parameter int unsigned TO_STEP_CYC = lfwk_pkg::TO_STEP_CYC,
   parameter int unsigned ART_SEC_CYC = lfwk_pkg::ART_SEC_CYC,
   parameter int unsigned SCAN_CYC = lfwk_pkg::SCAN_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [2:0] carrier_det,
   input wire logic rx_chip,
   input wire logic [4:0] rssi_in,
   input wire logic agc_dec,
   input wire logic agc_inc,
   input wire logic cal_ref_host,
   input wire logic cal_ref_lc,
   output logic wake,
   output logic rx_bit_out,
   output logic rx_clock_out,
   output logic [2:0] chan_active,
   output logic [3:0] gain,
   output logic clk_use_rc,
   output logic freq_tol_relaxed
);
   // ************************************************
   // helpers
   // ************************************************
   function automatic logic [31:0] lfwk_expand(input logic [15:0] p);
      logic [31:0] e;
      e = 32'h0;
      for (int i = 0; i < 16; i++) begin
         e[2*i+1] = ~p[i];
         e[2*i] = p[i];
      end
      return e;
   endfunction : lfwk_expand

   function automatic logic [2:0] lfwk_next_ch(input logic [2:0] cur, input logic [2:0] en);
      logic [2:0] c;
      c = $onehot(cur) ? cur : 3'h4;
      for (int i = 0; i < 3; i++) begin
         c = {c[1:0], c[2]};
         if ((c & en) != 3'h0) begin
            return c;
         end
      end
      return 3'h0;
   endfunction : lfwk_next_ch

   lfwk_pkg::lfwk_state_t s;
   lfwk_pkg::lfwk_state_t n;
   logic [3:0] cmd;
   logic [25:0] acc_sum;
   logic [31:0] to_lim;
   logic [31:0] sh;
   logic [31:0] status;
   logic [5:0] chip_len;
   logic [6:0] plen;
   logic tick, chip_stb, carrier, hit, wake_set, wake_clr, to_hit, art_hit;
   logic false_evt, agc_win, cal_ref, cal_rise, dout;
   logic [2:0] chen;
   logic [1:0] lp_mode;
   logic burst_only, updn, mask, disp, corr, manch, p32, dbl;

   assign chen = s.ctrl[lfwk_pkg::C_CHEN +: 3];
   assign lp_mode = s.ctrl[lfwk_pkg::C_LP +: 2];
   assign burst_only = s.ctrl[lfwk_pkg::C_BURST];
   assign updn = s.ctrl[lfwk_pkg::C_UPDN];
   assign mask = s.ctrl[lfwk_pkg::C_MASK];
   assign disp = s.ctrl[lfwk_pkg::C_DISP];
   assign corr = s.ctrl[lfwk_pkg::C_CORR];
   assign manch = s.ctrl[lfwk_pkg::C_MANCH];
   assign p32 = s.ctrl[lfwk_pkg::C_P32];
   assign dbl = s.ctrl[lfwk_pkg::C_DBL];

   // ************************************************
   // next state
   // ************************************************
   always_comb begin
      n = s;
      cmd = 4'h0;
      status = 32'h0;
      status[lfwk_pkg::S_WAKE] = s.wake;
      status[lfwk_pkg::S_SEQ +: 3] = s.st;
      status[lfwk_pkg::S_FALSE +: 8] = s.false_cnt;
      status[lfwk_pkg::S_RSSI +: 5] = s.rssi_held;
      status[lfwk_pkg::S_GAIN +: 4] = s.gain;
      status[lfwk_pkg::S_CHAN +: 3] = s.chan_active;
      status[lfwk_pkg::S_CAL] = s.cal_busy;
      // one wait state: answer prepared in the first access cycle
      n.pready = psel & penable & ~s.pready;
      n.pslverr = 1'b0;
      n.prdata = 32'h0;
      if (psel & penable & ~s.pready) begin
         if (paddr == lfwk_pkg::ADDR_CTRL) begin
            n.prdata = 32'(s.ctrl);
         end else if (paddr == lfwk_pkg::ADDR_PATTERN) begin
            n.prdata = 32'(s.pattern);
         end else if (paddr == lfwk_pkg::ADDR_SYMDIV) begin
            n.prdata = 32'(s.symdiv);
         end else if (paddr == lfwk_pkg::ADDR_ARTPER) begin
            n.prdata = 32'(s.artper);
         end else if (paddr == lfwk_pkg::ADDR_STATUS) begin
            n.prdata = status;
         end else if (paddr == lfwk_pkg::ADDR_CALRES) begin
            n.prdata = 32'(s.cal_res);
         end else if (paddr != lfwk_pkg::ADDR_CMD) begin
            n.pslverr = 1'b1;
         end
      end
      if (psel & penable & s.pready & pwrite) begin
         if (paddr == lfwk_pkg::ADDR_CTRL) begin
            n.ctrl = pwdata[19:0];
         end else if (paddr == lfwk_pkg::ADDR_PATTERN) begin
            n.pattern = pwdata[15:0];
         end else if (paddr == lfwk_pkg::ADDR_SYMDIV) begin
            // clamped so a chip never lasts under four ticks
            if (pwdata[6:0] < lfwk_pkg::SYMDIV_MIN || pwdata[31:7] != 25'h0) begin
               n.symdiv = (pwdata[31:7] != 25'h0) ? lfwk_pkg::SYMDIV_MAX : lfwk_pkg::SYMDIV_MIN;
            end else if (pwdata[6:0] > lfwk_pkg::SYMDIV_MAX) begin
               n.symdiv = lfwk_pkg::SYMDIV_MAX;
            end else begin
               n.symdiv = pwdata[6:0];
            end
         end else if (paddr == lfwk_pkg::ADDR_ARTPER) begin
            if (pwdata[12:0] == 13'h0) begin
               n.artper = 13'h0001;
            end else if (pwdata[12:0] > lfwk_pkg::ARTPER_MAX || pwdata[31:13] != 19'h0) begin
               n.artper = lfwk_pkg::ARTPER_MAX;
            end else begin
               n.artper = pwdata[12:0];
            end
         end else if (paddr == lfwk_pkg::ADDR_CMD) begin
            cmd = pwdata[3:0];
         end
      end

      // 32.768 khz tick from pclk by fractional accumulation
      acc_sum = {1'b0, s.acc} + 26'(lfwk_pkg::LF_HZ);
      tick = acc_sum >= 26'(lfwk_pkg::PCLK_HZ);
      n.acc = tick ? 25'(acc_sum - 26'(lfwk_pkg::PCLK_HZ)) : acc_sum[24:0];
      if (tick) begin
         n.gen_clk = ~s.gen_clk;
      end

      // chip timing, resynchronised on every data edge
      chip_len = s.symdiv[6:1];
      chip_stb = 1'b0;
      n.rx_prev = rx_chip;
      if (rx_chip != s.rx_prev) begin
         n.chip_ph = 6'h0;
      end else if (tick) begin
         n.chip_ph = (s.chip_ph >= chip_len - 6'h1) ? 6'h0 : s.chip_ph + 6'h1;
         chip_stb = (s.chip_ph == {1'b0, chip_len[5:1]});
      end

      // correlator
      sh = {s.shreg[30:0], rx_chip};
      plen = p32 ? lfwk_pkg::PLEN32 : lfwk_pkg::PLEN16;
      hit = p32 ? (sh == lfwk_expand(s.pattern)) : (sh[15:0] == s.pattern);
      carrier = (carrier_det & s.chan_active) != 3'h0;
      wake_set = 1'b0;
      false_evt = 1'b0;
      case (s.st)
         lfwk_pkg::ST_IDLE: begin
            if (carrier) begin
               n.st = lfwk_pkg::ST_BURST;
               n.gain = lfwk_pkg::GAIN_MAX;
            end
         end
         lfwk_pkg::ST_BURST: begin
            if (!carrier) begin
               n.chip_n = 7'h0;
               n.pre_cnt = 6'h0;
               n.chip_odd = 1'b0;
               if (corr) begin
                  n.st = lfwk_pkg::ST_PREAMB;
               end else begin
                  n.st = lfwk_pkg::ST_DATA;
                  wake_set = 1'b1;
               end
            end
         end
         lfwk_pkg::ST_PREAMB: begin
            if (chip_stb) begin
               n.shreg = sh;
               n.chip_n = s.chip_n + 7'h1;
               n.pre_cnt = (sh[0] != s.shreg[0]) ? s.pre_cnt + 6'h1 : 6'h0;
               if (n.pre_cnt >= lfwk_pkg::PRE_MIN_CHIPS) begin
                  n.st = lfwk_pkg::ST_PATT;
                  n.chip_n = 7'h0;
               end else if (s.chip_n == lfwk_pkg::PRE_MAX_CHIPS) begin
                  n.st = lfwk_pkg::ST_IDLE;
                  false_evt = 1'b1;
               end
            end
         end
         lfwk_pkg::ST_PATT: begin
            if (chip_stb) begin
               n.shreg = sh;
               n.chip_n = s.chip_n + 7'h1;
               if (hit) begin
                  n.chip_n = 7'h0;
                  if (dbl) begin
                     n.st = lfwk_pkg::ST_PATT2;
                  end else begin
                     n.st = lfwk_pkg::ST_DATA;
                     wake_set = 1'b1;
                  end
               end else if (s.chip_n == plen + lfwk_pkg::PAT_SLACK) begin
                  n.st = lfwk_pkg::ST_IDLE;
                  false_evt = 1'b1;
               end
            end
         end
         lfwk_pkg::ST_PATT2: begin
            if (chip_stb) begin
               n.shreg = sh;
               n.chip_n = s.chip_n + 7'h1;
               // second copy must follow back to back
               if (s.chip_n == plen - 7'h1) begin
                  if (hit) begin
                     n.st = lfwk_pkg::ST_DATA;
                     wake_set = 1'b1;
                  end else begin
                     n.st = lfwk_pkg::ST_IDLE;
                     false_evt = 1'b1;
                  end
               end
            end
         end
         lfwk_pkg::ST_DATA: begin
            if (chip_stb) begin
               n.chip_odd = ~s.chip_odd;
               if (s.chip_odd) begin
                  n.dec_bit = rx_chip;
                  n.rec_clk = ~s.rec_clk;
               end
            end
         end
         default: begin
            n.st = lfwk_pkg::ST_IDLE;
         end
      endcase

      // artificial wakeup
      art_hit = 1'b0;
      if (s.ctrl[lfwk_pkg::C_ART]) begin
         if (s.sec_cnt >= ART_SEC_CYC - 1) begin
            n.sec_cnt = 32'h0;
            if (s.art_sec >= s.artper - 13'h1) begin
               n.art_sec = 13'h0;
               art_hit = 1'b1;
            end else begin
               n.art_sec = s.art_sec + 13'h1;
            end
         end else begin
            n.sec_cnt = s.sec_cnt + 32'h1;
         end
      end else begin
         n.sec_cnt = 32'h0;
         n.art_sec = 13'h0;
      end

      // wake: set wins over clear; code 0 means no timeout
      to_lim = 32'(32'(s.ctrl[lfwk_pkg::C_TO +: 3]) * TO_STEP_CYC);
      to_hit = s.wake && to_lim != 32'h0 && s.to_cnt >= to_lim - 32'h1;
      wake_set = wake_set | art_hit;
      wake_clr = cmd[lfwk_pkg::K_CLRWAKE] | to_hit;
      n.wake = wake_set | (s.wake & ~wake_clr);
      n.to_cnt = (s.wake && !to_hit && !wake_set) ? s.to_cnt + 32'h1 : 32'h0;
      if (s.st == lfwk_pkg::ST_DATA && !n.wake) begin
         n.st = lfwk_pkg::ST_IDLE;
      end

      // gain control
      agc_win = burst_only ? (s.st == lfwk_pkg::ST_BURST) : (s.st != lfwk_pkg::ST_IDLE);
      if (agc_win) begin
         if (agc_dec && s.gain != 4'h0) begin
            n.gain = s.gain - 4'h1;
         end else if (agc_inc && updn && s.gain != lfwk_pkg::GAIN_MAX) begin
            n.gain = s.gain + 4'h1;
         end
      end
      if (cmd[lfwk_pkg::K_RSSI]) begin
         n.rssi_held = 5'h0;
      end else if (s.st != lfwk_pkg::ST_IDLE) begin
         if (!updn) begin
            n.rssi_held = (rssi_in > s.rssi_held) ? rssi_in : s.rssi_held;
         end else begin
            n.rssi_held = rssi_in;
         end
      end

      // false wakeup counter, wraps at 8 bits
      if (cmd[lfwk_pkg::K_FALSE]) begin
         n.false_cnt = false_evt ? 8'h01 : 8'h00;
      end else if (false_evt) begin
         n.false_cnt = s.false_cnt + 8'h01;
      end

      // channel scan when lp_mode is nonzero (mode 0 follows chen); held on one channel while a reception runs
      if (lp_mode == 2'h0) begin
         n.chan_active = chen;
         n.scan_cnt = 32'h0;
      end else if (s.st != lfwk_pkg::ST_IDLE && (s.chan_active & ~chen) == 3'h0) begin
         n.scan_cnt = 32'h0;
      end else if (s.scan_cnt >= SCAN_CYC - 1 || !$onehot(s.chan_active) ||
                   (s.chan_active & ~chen) != 3'h0) begin
         n.chan_active = lfwk_next_ch(s.chan_active, chen);
         n.scan_cnt = 32'h0;
      end else begin
         n.scan_cnt = s.scan_cnt + 32'h1;
      end

      // data and clock pins
      dout = (manch && s.st == lfwk_pkg::ST_DATA) ? s.dec_bit : rx_chip;
      n.rx_bit_out = (mask && !s.wake) ? 1'b0 : dout;
      n.rx_clock_out = disp ? s.gen_clk : (manch & s.rec_clk);

      // rc calibration: pclk cycles over one reference period, less one
      cal_ref = s.ctrl[lfwk_pkg::C_CALSRC] ? cal_ref_lc : cal_ref_host;
      n.cal_prev = cal_ref;
      cal_rise = cal_ref & ~s.cal_prev;
      if (cmd[lfwk_pkg::K_CAL] && s.ctrl[lfwk_pkg::C_RC]) begin
         n.cal_busy = 1'b1;
         n.cal_arm = 1'b0;
         n.cal_cnt = 16'h0;
      end else if (s.cal_busy) begin
         if (!s.cal_arm) begin
            n.cal_arm = cal_rise;
         end else if (cal_rise) begin
            n.cal_res = s.cal_cnt;
            n.cal_busy = 1'b0;
         end else begin
            n.cal_cnt = s.cal_cnt + 16'h1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= lfwk_pkg::STATE_RST;
      end else begin
         s <= n;
      end
   end

   assign prdata = s.prdata;
   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign wake = s.wake;
   assign rx_bit_out = s.rx_bit_out;
   assign rx_clock_out = s.rx_clock_out;
   assign chan_active = s.chan_active;
   assign gain = s.gain;
   assign clk_use_rc = s.ctrl[lfwk_pkg::C_RC];
   assign freq_tol_relaxed = s.ctrl[lfwk_pkg::C_TOL];

   // ************************************************
   // checks
   // ************************************************
   chan_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
      lp_mode == 2'h0 |=> chan_active == $past(chen))
      else $error("channels do not follow enables");
   lp_single_a: assert property (@(posedge pclk) disable iff (!presetn)
      lp_mode != 2'h0 |=> $onehot0(chan_active))
      else $error("more than one channel active");
   cal_result_a: assert property (@(posedge pclk) disable iff (!presetn)
      s.cal_busy && s.cal_arm && cal_rise && !cmd[lfwk_pkg::K_CAL]
      |=> !s.cal_busy && s.cal_res == $past(s.cal_cnt))
      else $error("calibration result not stored");
   burst_gain_a: assert property (@(posedge pclk) disable iff (!presetn)
      burst_only && s.st != lfwk_pkg::ST_BURST && s.st != lfwk_pkg::ST_IDLE |=> $stable(gain))
      else $error("gain moved outside first burst");
   gain_down_a: assert property (@(posedge pclk) disable iff (!presetn)
      !updn && s.st != lfwk_pkg::ST_IDLE |=> gain <= $past(gain))
      else $error("gain rose without up-down");
   mask_data_a: assert property (@(posedge pclk) disable iff (!presetn)
      mask && !wake |=> !rx_bit_out)
      else $error("data not masked before wake");
   match_wake_a: assert property (@(posedge pclk) disable iff (!presetn)
      s.st == lfwk_pkg::ST_PATT && chip_stb && hit && !dbl
      |=> wake && s.st == lfwk_pkg::ST_DATA)
      else $error("match did not raise wake");
   direct_rx_a: assert property (@(posedge pclk) disable iff (!presetn)
      s.st == lfwk_pkg::ST_BURST && !carrier && !corr |=> s.st == lfwk_pkg::ST_DATA && wake)
      else $error("no direct data reception");
   double_pat_a: assert property (@(posedge pclk) disable iff (!presetn)
      s.st == lfwk_pkg::ST_PATT && chip_stb && hit && dbl && !wake_set
      |=> s.st == lfwk_pkg::ST_PATT2 && wake == $past(wake))
      else $error("double pattern woke early");
   wake_timeout_a: assert property (@(posedge pclk) disable iff (!presetn)
      to_hit && !wake_set |=> !wake)
      else $error("timeout did not drop wake");
   wake_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      cmd[lfwk_pkg::K_CLRWAKE] && !wake_set |=> !wake ##1 !wake || wake_set)
      else $error("clear-wake ignored");
   false_count_a: assert property (@(posedge pclk) disable iff (!presetn)
      false_evt && !cmd[lfwk_pkg::K_FALSE] |=> s.false_cnt == $past(s.false_cnt) + 8'h01)
      else $error("false wakeup not counted");
   rssi_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
      cmd[lfwk_pkg::K_RSSI] |=> s.rssi_held == 5'h0)
      else $error("rssi not reset");
   wake_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      wake && !wake_clr |=> wake)
      else $error("wake dropped on its own");
endmodule : lfwk_top

// ===== verif/lf_wakeup_correlator_tb.sv
// lf_wakeup_correlator_tb: self-checking bench of the wake-up correlator
`timescale 1ns/100ps
module lf_wakeup_correlator_tb;
   logic pclk, presetn, psel, penable, pwrite, rx_chip, wake, pready, pslverr, e, start, busy;
   logic clk_use_rc, freq_tol_relaxed, agc_dec, agc_inc, cal_ref_host;
   logic [3:0] gain;
   logic [2:0] carrier_det, chan_active;
   logic [4:0] rssi_in;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, r, x;
   int n_mismatch = 0, comparisons = 0, cyc = 0, seed = 31679, n;
   lfwk_top #(.TO_STEP_CYC(20), .ART_SEC_CYC(50), .SCAN_CYC(10)) i_dut (.pclk, .presetn,
      .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .carrier_det,
      .rx_chip, .rssi_in, .agc_dec, .agc_inc, .cal_ref_host,
      .cal_ref_lc(1'b0), .wake, .rx_bit_out(), .rx_clock_out(), .chan_active, .gain,
      .clk_use_rc, .freq_tol_relaxed);
   lfwk_tx i_tx (.pclk, .start, .pat(16'h9669), .carrier_det, .rx_chip, .busy);
   // ***
   // helpers
   // ***
   function automatic logic [31:0] clampsym(input logic [31:0] d);
      return (d < 32768 / 4096) ? 32768 / 4096 : (d > 32768 / 512) ? 32768 / 512 : d;
   endfunction : clampsym
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
         n_mismatch++;
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(r, exp);
   endtask : rd
   task automatic tally_and_finish();
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : tally_and_finish
   // ***
   // clock, watchdog and sequence
   // ***
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      // host reference: 16-cycle period
      cal_ref_host <= cyc[3];
      if (cyc == 95000) begin
         n_mismatch++;
         tally_and_finish();
      end
   end
   initial begin
      {presetn, psel, penable, pwrite, start, paddr, pwdata, rssi_in} = '0;
      {agc_dec, agc_inc, cal_ref_host} = '0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      chk({clk_use_rc, chan_active}, 4'h7);
      rd(8'h00, 32'h807);
      rd(8'h04, 32'h9669);
      apb(1'b0, 8'h1c, 32'h0);
      chk(e, 1'b1);
      apb(1'b1, 8'h00, 32'h08825);
      repeat (3) @(posedge pclk);
      chk({freq_tol_relaxed, clk_use_rc, chan_active}, 5'h1d);
      apb(1'b1, 8'h00, 32'h0080f);
      for (int i = 0; i < 6; i++) begin
         repeat (7) @(posedge pclk);
         chk($countones(chan_active), 1);
         x = (i < 2) ? i * 127 : $random(seed) & 32'h7f;
         apb(1'b1, 8'h08, x);
         rd(8'h08, clampsym(x));
      end
      apb(1'b1, 8'h00, 32'h00807);
      apb(1'b1, 8'h08, 32'h8);
      rssi_in <= 5'($random(seed));
      start <= 1'b1;
      @(posedge pclk);
      start <= 1'b0;
      @(posedge pclk);
      wait (busy === 1'b0);
      rssi_in <= 5'h0;
      repeat (200) @(posedge pclk);
      chk(wake, 1'b1);
      apb(1'b1, 8'h10, 32'h2);
      rd(8'h14, 32'h0fe0000b);
      chk(r[20:16], 5'h0);
      agc_dec <= 1'b1;
      repeat (3) @(posedge pclk);
      agc_dec <= 1'b0;
      agc_inc <= 1'b1;
      repeat (2) @(posedge pclk);
      agc_inc <= 1'b0;
      @(posedge pclk);
      chk(gain, 4'hc);
      apb(1'b1, 8'h10, 32'h1);
      repeat (2) @(posedge pclk);
      chk(wake, 1'b0);
      apb(1'b1, 8'h00, 32'h00827);
      apb(1'b1, 8'h10, 32'h8);
      repeat (40) @(posedge pclk);
      rd(8'h18, 32'hf);
      // art every 50 cycles, timeout code 1 drops wake after 20
      apb(1'b1, 8'h00, 32'h90807);
      while (wake !== 1'b1) @(posedge pclk);
      n = 0;
      while (wake === 1'b1) begin
         @(posedge pclk);
         n++;
      end
      chk(n, 20);
      while (wake !== 1'b1) begin
         @(posedge pclk);
         n++;
      end
      chk(n, 50);
      tally_and_finish();
   end
endmodule : lf_wakeup_correlator_tb

// ===== verif/lfwk_tx.sv
// lfwk_tx: transmitter model, burst then preamble then pattern chips
`timescale 1ns/100ps
module lfwk_tx #(parameter int CP = 2441) (
   input wire logic pclk,
   input wire logic start,
   input wire logic [15:0] pat,
   output logic [2:0] carrier_det,
   output logic rx_chip,
   output logic busy
);
   // ***
   // frame
   // ***
   initial begin
      carrier_det = 3'h0;
      rx_chip = 1'b0;
      busy = 1'b0;
      forever begin
         @(posedge pclk);
         if (start) begin
            busy <= 1'b1;
            carrier_det <= 3'h7;
            repeat (3 * CP) @(posedge pclk);
            carrier_det <= 3'h0;
            for (int i = 0; i < 25; i++) begin
               rx_chip <= (i < 9) ? i[0] : pat[24 - i];
               repeat (CP) @(posedge pclk);
            end
            busy <= 1'b0;
         end else begin
            // released line toggles, so a stale level is never seen
            rx_chip <= ~rx_chip;
         end
      end
   end
endmodule : lfwk_tx
